// ==== spi_status_pkg.sv ====
// Constants and carrier types for the serial status block
package spi_status_pkg;
	// Register byte offsets
	localparam logic [3:0] STATUS_OFS = 4'h0;
	localparam logic [3:0] CONTROL_OFS = 4'h4;
	localparam logic [3:0] EVENT_EN_OFS = 4'h8;
	localparam logic [3:0] DATA_PORT_OFS = 4'hc;
	// Status field positions
	localparam int RX_COUNT_LSB = 24;
	localparam int TX_COUNT_LSB = 16;
	localparam int FRAME_ERR_BIT = 12;
	localparam int BUSY_BIT = 11;
	localparam int UNDERRUN_BIT = 8;
	localparam int SHIFTER_EMPTY_BIT = 7;
	localparam int OVERFLOW_BIT = 6;
	localparam int RX_EMPTY_BIT = 5;
	localparam int TX_EMPTY_BIT = 3;
	localparam int TX_FULL_BIT = 1;
	localparam int RX_FULL_BIT = 0;
	// Control and event enable field positions
	localparam int MODULE_ON_BIT = 15;
	localparam int FIFO_MODE_BIT = 16;
	localparam int FRAMED_BIT = 17;
	localparam int OVF_EVENT_EN_BIT = 11;
	localparam int FRM_EVENT_EN_BIT = 12;
	// Reset values and sizes
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	localparam int FIFO_DEPTH = 16;
	localparam int WORD_BITS = 8;
	localparam int SYNC_STAGES = 2;

	// One register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	// Link pins sampled from outside
	typedef struct packed {
		logic sck;
		logic sdi;
		logic ss_n;
	} link_in_t;
endpackage : spi_status_pkg

// ==== pin_sync.sv ====
// Two-stage synchroniser for a group of pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RESET_LEVEL = '1
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	// One pair of flops per pin; the first stage feeds only the second
	genvar i;
	for (i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				// Reset to the pin's idle level so no false edge follows reset
				stage1[i] <= RESET_LEVEL[i];
				sync_out[i] <= RESET_LEVEL[i];
			end else begin
				stage1[i] <= async_in[i];
				sync_out[i] <= stage1[i];
			end
		end
	end
endmodule : pin_sync

// ==== spi_status_flags.sv ====
// Serial unit status flags, buffers and slave shifter
`timescale 1ns/1ps
module spi_status_flags
	import spi_status_pkg::*;
#(
	parameter int DEPTH = spi_status_pkg::FIFO_DEPTH,
	parameter int WBITS = spi_status_pkg::WORD_BITS
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire spi_status_pkg::bus_req_t bus_req,
	output logic [31:0] rdata,
	input wire spi_status_pkg::link_in_t link_in,
	output logic link_sdo,
	output logic link_sdo_oe,
	output logic error_event
);
	import spi_status_pkg::*;

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(WBITS);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [31:0] control;
	logic [31:0] event_en;
	logic [WBITS-1:0] tx_mem [DEPTH];
	logic [WBITS-1:0] rx_mem [DEPTH];
	logic [PW-1:0] cpu_write_pointer;
	logic [PW-1:0] shifter_read_pointer;
	logic [PW-1:0] shifter_write_pointer;
	logic [PW-1:0] cpu_read_pointer;
	logic [WBITS-1:0] shift_tx;
	logic [WBITS-1:0] shift_rx;
	logic [CW-1:0] bit_count;
	logic shifter_loaded;
	logic frame_error_flag;
	logic tx_underrun_flag;
	logic rx_overflow_flag;
	logic [2:0] link_sync;
	logic sck_d;
	logic ss_n_d;
	logic started;

	////////////////////////////////////////////////////////////////////////
	// Link pin synchronisers

	pin_sync #(
		.WIDTH(3),
		.RESET_LEVEL(3'h1) // Clock low, data low, select high
	) u_sync (
		.mclk(mclk),
		.rstn(rstn),
		.async_in({link_in.sck, link_in.sdi, link_in.ss_n}),
		.sync_out(link_sync)
	);

	wire sck_s = link_sync[2];
	wire sdi_s = link_sync[1];
	wire ss_n_s = link_sync[0];

	// Edge detection on synchronised levels
	wire sck_rise = sck_s & ~sck_d;
	wire sck_fall = ~sck_s & sck_d;
	// Frame start needs no edge of its own; the first clock rise loads the shifter
	wire ss_rise = ss_n_s & ~ss_n_d;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sck_d <= 1'b0;
			ss_n_d <= 1'b1;
		end else begin
			sck_d <= sck_s;
			ss_n_d <= ss_n_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control fields

	wire module_on = control[MODULE_ON_BIT];
	wire fifo_mode_select = control[FIFO_MODE_BIT];
	wire framed_mode_enable = control[FRAMED_BIT];
	wire overflow_event_enable = event_en[OVF_EVENT_EN_BIT];
	wire frame_error_event_enable = event_en[FRM_EVENT_EN_BIT];

	////////////////////////////////////////////////////////////////////////
	// Register decode

	wire sel_status = bus_req.addr == STATUS_OFS;
	wire sel_control = bus_req.addr == CONTROL_OFS;
	wire sel_event = bus_req.addr == EVENT_EN_OFS;
	wire sel_data = bus_req.addr == DATA_PORT_OFS;
	wire wr_status = bus_req.wr & sel_status;
	wire wr_control = bus_req.wr & sel_control;
	wire wr_event = bus_req.wr & sel_event;
	wire wr_data = bus_req.wr & sel_data;
	wire rd_data = bus_req.rd & sel_data;

	// Turning the unit off holds buffers and error flags clear
	wire unit_clear = ~module_on;

	////////////////////////////////////////////////////////////////////////
	// Buffer occupancy

	wire [PW-1:0] tx_used = cpu_write_pointer - shifter_read_pointer;
	wire [PW-1:0] rx_used = shifter_write_pointer - cpu_read_pointer;
	wire [4:0] tx_fifo_count = 5'(tx_used);
	wire [4:0] rx_fifo_count = 5'(rx_used);
	wire [PW-1:0] cwp_next = cpu_write_pointer + PW'(1);
	wire [PW-1:0] swp_next = shifter_write_pointer + PW'(1);

	// Full and empty follow the pointers in FIFO mode, one slot otherwise
	wire tx_full_fifo = cwp_next == shifter_read_pointer;
	wire rx_full_fifo = swp_next == cpu_read_pointer;
	wire tx_full_single = tx_used != '0;
	wire rx_full_single = rx_used != '0;
	wire tx_buffer_full_flag = fifo_mode_select ? tx_full_fifo : tx_full_single;
	wire rx_buffer_full_flag = fifo_mode_select ? rx_full_fifo : rx_full_single;
	wire tx_buffer_empty_flag = cpu_write_pointer == shifter_read_pointer;
	wire rx_fifo_empty_flag = cpu_read_pointer == shifter_write_pointer;
	wire shifter_empty_flag = ~shifter_loaded;

	// Writes into a full buffer and reads of an empty one are dropped
	wire tx_push = wr_data & module_on & ~tx_buffer_full_flag;
	wire rx_pop = rd_data & module_on & ~rx_fifo_empty_flag;

	////////////////////////////////////////////////////////////////////////
	// Shifter events

	wire link_active = module_on & ~ss_n_s;
	wire word_start = link_active & sck_rise & (bit_count == '0);
	wire word_done = link_active & sck_rise & (bit_count == CW'(WBITS - 1));
	wire tx_pop = word_start & ~tx_buffer_empty_flag;
	wire underrun = word_start & tx_buffer_empty_flag & framed_mode_enable;
	wire rx_push = word_done & ~rx_buffer_full_flag;
	wire overflow = word_done & rx_buffer_full_flag;
	wire frame_error = module_on & framed_mode_enable & ss_rise
		& (bit_count != '0);
	wire [WBITS-1:0] rx_word = {shift_rx[WBITS-2:0], sdi_s};

	// Busy while a frame is selected or a word still sits in the shifter
	wire unit_busy_flag = link_active | shifter_loaded | started;

	////////////////////////////////////////////////////////////////////////
	// Control registers

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			control <= CONTROL_RESET;
		end else if (wr_control) begin
			control <= bus_req.wdata;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			event_en <= CONTROL_RESET;
		end else if (wr_event) begin
			event_en <= bus_req.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Buffer storage

	always_ff @(posedge mclk) begin
		if (tx_push) begin
			tx_mem[cpu_write_pointer] <= bus_req.wdata[WBITS-1:0];
		end
		if (rx_push) begin
			rx_mem[shifter_write_pointer] <= rx_word;
		end
	end

	// Transmit pointers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cpu_write_pointer <= '0;
			shifter_read_pointer <= '0;
		end else if (unit_clear) begin
			cpu_write_pointer <= '0;
			shifter_read_pointer <= '0;
		end else begin
			if (tx_push) begin
				cpu_write_pointer <= cwp_next;
			end
			if (tx_pop) begin
				shifter_read_pointer <= shifter_read_pointer + PW'(1);
			end
		end
	end

	// Receive pointers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			shifter_write_pointer <= '0;
			cpu_read_pointer <= '0;
		end else if (unit_clear) begin
			shifter_write_pointer <= '0;
			cpu_read_pointer <= '0;
		end else begin
			if (rx_push) begin
				shifter_write_pointer <= swp_next;
			end
			if (rx_pop) begin
				cpu_read_pointer <= cpu_read_pointer + PW'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shift engine, slave side

	// Receive sampling and bit counting on rising link clock
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			shift_rx <= '0;
			bit_count <= '0;
		end else if (!link_active) begin
			bit_count <= '0;
		end else if (sck_rise) begin
			shift_rx <= rx_word;
			bit_count <= bit_count + CW'(1);
		end
	end

	// Transmit load at word start, shift on falling link clock
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			shift_tx <= '0;
			shifter_loaded <= 1'b0;
			started <= 1'b0;
		end else if (!link_active) begin
			shifter_loaded <= 1'b0;
			started <= 1'b0;
		end else begin
			if (word_start) begin
				shift_tx <= tx_pop ? tx_mem[shifter_read_pointer] : '0;
				shifter_loaded <= tx_pop;
				started <= 1'b1;
			end else if (sck_fall) begin
				shift_tx <= {shift_tx[WBITS-2:0], 1'b0};
			end
			if (word_done) begin
				shifter_loaded <= 1'b0;
				started <= 1'b0;
			end
		end
	end

	// Serial output from a flop; driven only while selected
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			link_sdo <= 1'b0;
			link_sdo_oe <= 1'b0;
		end else begin
			link_sdo <= shift_tx[WBITS-1];
			link_sdo_oe <= link_active;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Error flags; a hardware set wins over a software clear

	wire clr_frame = wr_status & ~bus_req.wdata[FRAME_ERR_BIT];
	wire clr_under = wr_status & ~bus_req.wdata[UNDERRUN_BIT];
	wire clr_over = wr_status & ~bus_req.wdata[OVERFLOW_BIT];

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			frame_error_flag <= 1'b0;
		end else if (frame_error) begin
			frame_error_flag <= 1'b1;
		end else if (clr_frame || unit_clear) begin
			frame_error_flag <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tx_underrun_flag <= 1'b0;
		end else if (underrun) begin
			tx_underrun_flag <= 1'b1;
		end else if (clr_under || unit_clear) begin
			tx_underrun_flag <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rx_overflow_flag <= 1'b0;
		end else if (overflow) begin
			rx_overflow_flag <= 1'b1;
		end else if (clr_over || unit_clear) begin
			rx_overflow_flag <= 1'b0;
		end
	end

	// Error event gated by its enables
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			error_event <= 1'b0;
		end else begin
			error_event <= (rx_overflow_flag & overflow_event_enable)
				| (frame_error_flag & frame_error_event_enable);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path

	// Status word; unimplemented ranges stay zero
	wire [31:0] status_word = {
		3'h0, rx_fifo_count,
		3'h0, tx_fifo_count,
		3'h0, frame_error_flag, unit_busy_flag, 2'h0, tx_underrun_flag,
		shifter_empty_flag, rx_overflow_flag, rx_fifo_empty_flag, 1'b0,
		tx_buffer_empty_flag, 1'b0, tx_buffer_full_flag, rx_buffer_full_flag
	};

	wire [31:0] data_word = {{(32 - WBITS){1'b0}}, rx_mem[cpu_read_pointer]};

	// Read mux; unmapped offsets answer zero
	wire [31:0] read_mux = sel_status ? status_word :
		sel_control ? control :
		sel_event ? event_en :
		(sel_data && !rx_fifo_empty_flag) ? data_word : 32'h0000_0000;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 32'h0000_0000;
		end else if (bus_req.rd) begin
			rdata <= read_mux;
		end else begin
			rdata <= 32'h0000_0000;
		end
	end
endmodule : spi_status_flags

// ==== spi_status_flags_checker.sv ====
// Concurrent checks on the ports of the serial status block
`timescale 1ns/1ps
module spi_status_flags_checker
	import spi_status_pkg::*;
#(
	parameter int DEPTH = spi_status_pkg::FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire spi_status_pkg::bus_req_t bus_req,
	input wire logic [31:0] rdata,
	input wire spi_status_pkg::link_in_t link_in,
	input wire logic link_sdo,
	input wire logic link_sdo_oe,
	input wire logic error_event
);
	logic [31:0] ctl;
	logic [31:0] ev;
	wire st_rd = bus_req.rd && bus_req.addr == STATUS_OFS;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////////////////////
	// Shadow copies of control and event enable writes
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctl <= '0;
			ev <= '0;
		end else if (bus_req.wr) begin
			if (bus_req.addr == CONTROL_OFS) ctl <= bus_req.wdata;
			if (bus_req.addr == EVENT_EN_OFS) ev <= bus_req.wdata;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	property p_idle_rd; !bus_req.rd |=> rdata == 32'h0; endproperty
	a_idle_rd: assert property (p_idle_rd) else $error("rdata not zero");
	property p_rsvd; st_rd |=> (rdata & 32'he0e0_e614) == 32'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
	property p_rx_empty; st_rd && ctl[FIFO_MODE_BIT] |=> rdata[5] == (rdata[28:24] == 5'h0);
	endproperty
	a_rx_empty: assert property (p_rx_empty) else $error("rx empty wrong");
	property p_rx_full; st_rd && ctl[FIFO_MODE_BIT] |=> rdata[0] == (rdata[28:24] == 5'(DEPTH-1));
	endproperty
	a_rx_full: assert property (p_rx_full) else $error("rx full wrong");
	property p_tx_full; st_rd && ctl[FIFO_MODE_BIT] |=> rdata[1] == (rdata[20:16] == 5'(DEPTH-1));
	endproperty
	a_tx_full: assert property (p_tx_full) else $error("tx full wrong");
	property p_off; st_rd && !ctl[MODULE_ON_BIT] && $past(!ctl[MODULE_ON_BIT])
		|=> rdata[3] && (rdata & 32'h1f1f_0003) == 32'h0; endproperty
	a_off: assert property (p_off) else $error("off state wrong");
	property p_evt_off; (ev[12:11] == 2'b00) [*2] |-> !error_event; endproperty
	a_evt_off: assert property (p_evt_off) else $error("event while masked");
	property p_oe_idle; link_in.ss_n [*4] |-> !link_sdo_oe; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("sdo driven unselected");
endmodule : spi_status_flags_checker

// ==== link_master.sv ====
// External link master model
`timescale 1ns/1ps
module link_master
	import spi_status_pkg::*;
(
	output spi_status_pkg::link_in_t lk,
	input wire logic sdo,
	input wire logic sdo_oe
);
	// Clock rests low; data flips when released so stale bits never pass
	initial lk = 3'b001;
	task sel(input logic v);
		lk.ss_n = v;
		lk.sdi = ~lk.sdi;
		#48;
	endtask : sel
	// Sends n bits MSB first, samples sdo just before each falling edge
	task word(input logic [7:0] b, input int n, output logic [7:0] g);
		g = '0;
		for (int i = 7; i > 7 - n; i--) begin
			lk.sdi = b[i];
			#24 lk.sck = 1;
			// A released data line reads as the inverse of what the block drives
			#24 g = {g[6:0], sdo_oe ? sdo : ~sdo};
			lk.sck = 0;
		end
		lk.sdi = ~lk.sdi;
	endtask : word
endmodule : link_master

// ==== spi_status_flags_bench.sv ====
// Self-checking testbench for the serial status block
`timescale 1ns/1ps
module spi_status_flags_bench;
	import spi_status_pkg::*;
	logic mclk = 0;
	logic rstn = 0;
	bus_req_t bus_req = '0;
	logic [31:0] rdata;
	logic [31:0] d;
	logic [7:0] g;
	link_in_t link_in;
	logic link_sdo;
	logic link_sdo_oe;
	logic error_event;
	int fails = 0;
	int check_count = 0;
	always #2 mclk = ~mclk;
	spi_status_flags u_dut (.mclk(mclk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
		.link_in(link_in), .link_sdo(link_sdo), .link_sdo_oe(link_sdo_oe),
		.error_event(error_event));
	link_master u_m (.lk(link_in), .sdo(link_sdo), .sdo_oe(link_sdo_oe));
	////////////////////////////////////////////////////////////////////////////////
	// Bus access and comparison helpers
	task chk(input string n, input logic [31:0] e, input logic [31:0] v);
		check_count++;
		if (v !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, v);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] w);
		@(posedge mclk);
		bus_req.addr <= a;
		bus_req.wdata <= w;
		bus_req.wr <= 1'b1;
		@(posedge mclk);
		bus_req.wr <= 1'b0;
		@(posedge mclk);
	endtask : wr
	task rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
		@(posedge mclk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge mclk);
		bus_req.rd <= 1'b0;
		#1 d = rdata;
		@(posedge mclk);
		chk(n, e, d & m);
	endtask : rc
	task evt(input logic e);
		repeat (3) @(posedge mclk);
		#1 chk("error_event", {31'h0, e}, {31'h0, error_event});
	endtask : evt
	task summarize;
		if (fails == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////////////
	// Watchdog against a hung handshake
	initial begin
		#200000;
		fails++;
		summarize();
	end
	// Main sequence
	initial begin
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		rc(STATUS_OFS, 32'hffff_ff5f, 32'h8, "reset status");
		wr(STATUS_OFS, 32'hffff_ffff);
		rc(STATUS_OFS, 32'hffff_ff5f, 32'h8, "ro status");
		rc(4'h2, 32'hffff_ffff, 32'h0, "unmapped");
		wr(CONTROL_OFS, 32'h0001_8000);
		for (int i = 0; i < 16; i++) wr(DATA_PORT_OFS, 32'h30 + i);
		rc(STATUS_OFS, 32'h001f_000a, 32'h000f_0002, "tx fifo full");
		fork
			begin
				u_m.sel(0);
				u_m.word(8'hc5, 8, g);
				chk("sdo word0", 32'h30, {24'h0, g});
				u_m.word(8'h3a, 8, g);
				chk("sdo word1", 32'h31, {24'h0, g});
				u_m.sel(1);
			end
			begin
				wait (!link_in.ss_n);
				repeat (8) @(posedge mclk);
				rc(STATUS_OFS, 32'h800, 32'h800, "busy");
				#1 chk("sdo_oe", 32'h1, {31'h0, link_sdo_oe});
			end
		join
		rc(STATUS_OFS, 32'h1f1f_08a0, 32'h020d_0080, "after frame");
		rc(DATA_PORT_OFS, 32'hff, 32'hc5, "rx word0");
		rc(DATA_PORT_OFS, 32'hff, 32'h3a, "rx word1");
		rc(STATUS_OFS, 32'h1f00_0020, 32'h20, "rx drained");
		u_m.sel(0);
		for (int i = 0; i < 16; i++) u_m.word(8'(i), 8, g);
		u_m.sel(1);
		rc(STATUS_OFS, 32'h1f1f_0041, 32'h0f00_0041, "rx fifo full");
		wr(EVENT_EN_OFS, 32'h800);
		evt(1'b1);
		wr(STATUS_OFS, 32'hffff_ffff);
		rc(STATUS_OFS, 32'h40, 32'h40, "ovf kept");
		wr(STATUS_OFS, 32'h0);
		rc(STATUS_OFS, 32'h40, 32'h0, "ovf cleared");
		evt(1'b0);
		for (int i = 0; i < 15; i++) rc(DATA_PORT_OFS, 32'hff, 32'(i), "rx fifo order");
		wr(CONTROL_OFS, 32'h0002_8000);
		wr(DATA_PORT_OFS, 32'h5a);
		rc(STATUS_OFS, 32'ha, 32'h2, "tx loaded");
		u_m.sel(0);
		u_m.word(8'h81, 8, g);
		chk("sdo single", 32'h5a, {24'h0, g});
		rc(STATUS_OFS, 32'hb, 32'h9, "rx landed");
		u_m.word(8'h7e, 8, g);
		u_m.word(8'he0, 3, g);
		u_m.sel(1);
		rc(STATUS_OFS, 32'h1141, 32'h1141, "errors");
		rc(DATA_PORT_OFS, 32'hff, 32'h81, "rx kept");
		rc(STATUS_OFS, 32'h1, 32'h0, "rx taken");
		wr(EVENT_EN_OFS, 32'h1000);
		evt(1'b1);
		wr(STATUS_OFS, 32'hffff_efff);
		rc(STATUS_OFS, 32'h1140, 32'h0140, "frame err cleared");
		evt(1'b0);
		wr(CONTROL_OFS, 32'h0);
		wr(CONTROL_OFS, 32'h0002_8000);
		rc(STATUS_OFS, 32'h140, 32'h0, "off on clears");
		summarize();
	end
endmodule : spi_status_flags_bench

bind spi_status_flags spi_status_flags_checker #(.DEPTH(DEPTH)) u_chk (.mclk(mclk), .rstn(rstn),
	.bus_req(bus_req), .rdata(rdata), .link_in(link_in), .link_sdo(link_sdo),
	.link_sdo_oe(link_sdo_oe), .error_event(error_event));
